// ### design/pbm_defines.svh
// Constants of the push-button menu controller: timing, register map, fields.
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH
`define PBM_CLK_KHZ      100000
`define PBM_HOLD_MS      5000
`define PBM_IDLE_MS      5000
`define PBM_SHOW_MS      5000
`define PBM_START_MS     2000
`define PBM_DEB_MS       10
`define PBM_BLINK_MS     250
`define PBM_MS2CYC(ms)   ((ms) * `PBM_CLK_KHZ)
`define PBM_REG_CTRL     4'h0
`define PBM_REG_STAT     4'h4
`define PBM_REG_ISTAT    4'h8
`define PBM_REG_IMASK    4'hC
`define PBM_CTRL_TWOSEG  0
`define PBM_CTRL_RST     32'h0000_0001
`define PBM_IMASK_RST    32'h0000_0000
`define PBM_STAT_PROTO   0
`define PBM_STAT_PRESS   1
`define PBM_STAT_SEL     4:2
`define PBM_STAT_STATE   15:8
`define PBM_PROTO_PNET   1'b0
`define PBM_PROTO_EIP    1'b1
`define PBM_EV_W         5
`define PBM_EV_MENU      0
`define PBM_EV_SAVE      1
`define PBM_EV_PROTO     2
`define PBM_EV_FACT      3
`define PBM_EV_IDLE      4
`define PBM_SEL_MAX_TWO  3'h4
`define PBM_SEL_MAX_ONE  3'h2
`endif

// ### design/pbm_pkg.sv
// Types shared by the push-button menu controller.
package pbm_pkg;
   typedef enum logic [1:0] {PBM_OFF, PBM_GREEN, PBM_RED, PBM_YELLOW} pbm_colour_t;
   typedef struct packed {
      pbm_colour_t colour;
      logic        flash;
      logic        lit;
   } pbm_led_t;
   typedef struct packed {
      logic       valid;
      logic [1:0] segs;
   } pbm_store_t;
   typedef enum {PBM_STARTUP, PBM_NORMAL, PBM_SEL, PBM_SAVE_WAIT, PBM_SHOW, PBM_PROTO,
                 PBM_FR_ARM, PBM_FR_WAIT, PBM_FR_FAIL} pbm_state_t;
   typedef enum {PBM_SK_SEG1, PBM_SK_SEG2, PBM_SK_BOTH, PBM_SK_PNET, PBM_SK_EIP} pbm_kind_t;
endpackage : pbm_pkg

// ### design/pbm_ctrl.sv
// Single push-button menu controller with register port and interrupt.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pbm_defines.svh"

// What this block does
// - Five-second hold in normal operation opens menu at segment one, yellow flash.
// - Hold with segment one selected stores its configuration, protected mode.
// - Segment-one LEDs flash green on success, red on failure, five seconds.
// - Short press at segment one selects segment two, its LEDs flash yellow.
// - Hold at segment two stores it; green or red flash for five seconds.
// - Two short presses select both segments; both LED groups flash yellow.
// - Hold at both stores both; memory LED steady green or red.
// - Five seconds without input in the menu returns to normal operation.
// - Fresh device starts with PROFINET protocol selected.
// - Two-segment variant: four presses EtherNet/IP, three PROFINET; fault LED flashes.
// - One-segment variant: two presses EtherNet/IP, one PROFINET; fault LED flashes.
// - Hold after protocol choice flashes both groups, switches, resets config, restarts.
// - Button held at power-up arms factory reset; fault LED flashes yellow.
// - After release, five-second press requests factory reset at restart.
// - Armed and idle five seconds: leave menu, restart without resetting.
// - Failed factory reset flashes button-function LED red, then restarts.
module pbm_ctrl
   import pbm_pkg::*;
#(
   parameter int unsigned HOLD_CYC  = `PBM_MS2CYC(`PBM_HOLD_MS),
   parameter int unsigned IDLE_CYC  = `PBM_MS2CYC(`PBM_IDLE_MS),
   parameter int unsigned SHOW_CYC  = `PBM_MS2CYC(`PBM_SHOW_MS),
   parameter int unsigned START_CYC = `PBM_MS2CYC(`PBM_START_MS),
   parameter int unsigned DEB_CYC   = `PBM_MS2CYC(`PBM_DEB_MS),
   parameter int unsigned BLINK_CYC = `PBM_MS2CYC(`PBM_BLINK_MS)
) (
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   input  wire logic        i_button,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_we,
   input  wire logic        i_re,
   output logic      [31:0] o_rdata,
   output logic             o_irq,
   output pbm_led_t         o_seg1_led,
   output pbm_led_t         o_seg2_led,
   output pbm_led_t         o_mem_led,
   output pbm_led_t         o_fault_status_led,
   output pbm_led_t         o_btn_fn_led,
   output pbm_store_t       o_store,
   input  wire logic        i_store_done,
   input  wire logic        i_store_ok,
   output logic             o_proto,
   output logic             o_proto_switch,
   output logic             o_fb_cfg_reset,
   output logic             o_restart,
   output logic             o_factory_req,
   input  wire logic        i_factory_done,
   input  wire logic        i_factory_ok
);

   pbm_state_t       st_reg;
   pbm_state_t       st_prev;
   pbm_kind_t        kind;
   logic             btn_s1, btn_s2, db_reg, db_q;
   logic [31:0]      deb_cnt, hold_cnt, tmr, blink_cnt;
   logic             short_ev, long_ev, blink;
   logic             tmr_clr, idle_out, show_end, start_end;
   logic [2:0]       sel_cnt, sel_max;
   logic             two_seg, fr_rel, res_ok;
   logic [1:0]       res_segs;
   logic [31:0]      ctrl_reg, istat_reg, imask_reg, istat_next;
   logic [`PBM_EV_W-1:0] ev;

   assign two_seg = ctrl_reg[`PBM_CTRL_TWOSEG];
   assign sel_max = two_seg ? `PBM_SEL_MAX_TWO : `PBM_SEL_MAX_ONE;

   // Pin is asynchronous to i_mclk
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         btn_s1 <= 1'b0;
         btn_s2 <= 1'b0;
      end else begin
         btn_s1 <= i_button;
         btn_s2 <= btn_s1;
      end
   end

   // Level must stay changed for DEB_CYC before it is believed
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         db_reg  <= 1'b0;
         db_q    <= 1'b0;
         deb_cnt <= 32'h0000_0000;
      end else begin
         db_q <= db_reg;
         if (btn_s2 == db_reg) begin
            deb_cnt <= 32'h0000_0000;
         end else if (deb_cnt >= DEB_CYC - 1) begin
            db_reg  <= btn_s2;
            deb_cnt <= 32'h0000_0000;
         end else begin
            deb_cnt <= deb_cnt + 32'h0000_0001;
         end
      end
   end

   // Long event fires once at the threshold while held, so the user sees the
   // reaction without releasing; the release that follows is then not short.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         hold_cnt <= 32'h0000_0000;
         long_ev  <= 1'b0;
         short_ev <= 1'b0;
      end else begin
         long_ev  <= db_reg && (hold_cnt == HOLD_CYC - 1);
         short_ev <= !db_reg && db_q && (hold_cnt < HOLD_CYC);
         if (!db_reg) begin
            hold_cnt <= 32'h0000_0000;
         end else if (hold_cnt < HOLD_CYC) begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
         end
      end
   end

   // One timer serves start-up, idle and result display
   assign tmr_clr   = (st_reg != st_prev) || (db_reg != db_q) || short_ev || long_ev;
   assign idle_out  = !db_reg && (tmr >= IDLE_CYC - 1);
   assign show_end  = tmr >= SHOW_CYC - 1;
   assign start_end = tmr >= START_CYC - 1;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         tmr     <= 32'h0000_0000;
         st_prev <= PBM_STARTUP;
      end else begin
         st_prev <= st_reg;
         if (tmr_clr) begin
            tmr <= 32'h0000_0000;
         end else if (tmr != 32'hFFFF_FFFF) begin
            tmr <= tmr + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         blink_cnt <= 32'h0000_0000;
         blink     <= 1'b0;
      end else if (blink_cnt >= BLINK_CYC - 1) begin
         blink_cnt <= 32'h0000_0000;
         blink     <= !blink;
      end else begin
         blink_cnt <= blink_cnt + 32'h0000_0001;
      end
   end

   always_comb begin
      kind = PBM_SK_SEG1;
      if (two_seg) begin
         if (sel_cnt == 3'h1) begin
            kind = PBM_SK_SEG2;
         end else if (sel_cnt == 3'h2) begin
            kind = PBM_SK_BOTH;
         end else if (sel_cnt == 3'h3) begin
            kind = PBM_SK_PNET;
         end else if (sel_cnt == 3'h4) begin
            kind = PBM_SK_EIP;
         end
      end else begin
         if (sel_cnt == 3'h1) begin
            kind = PBM_SK_PNET;
         end else if (sel_cnt == 3'h2) begin
            kind = PBM_SK_EIP;
         end
      end
   end

   // Menu sequencing and the one-cycle commands to storage, protocol and reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_reg         <= PBM_STARTUP;
         sel_cnt        <= 3'h0;
         fr_rel         <= 1'b0;
         res_ok         <= 1'b0;
         res_segs       <= 2'h0;
         o_store        <= '0;
         o_proto        <= `PBM_PROTO_PNET;
         o_proto_switch <= 1'b0;
         o_fb_cfg_reset <= 1'b0;
         o_restart      <= 1'b0;
         o_factory_req  <= 1'b0;
         ev             <= '0;
      end else begin
         o_store.valid  <= 1'b0;
         o_proto_switch <= 1'b0;
         o_fb_cfg_reset <= 1'b0;
         o_restart      <= 1'b0;
         o_factory_req  <= 1'b0;
         ev             <= '0;
         case (st_reg)
            PBM_STARTUP: begin
               // Button caught at the end of the LED start sequence
               fr_rel <= 1'b0;
               if (start_end) begin
                  st_reg <= db_reg ? PBM_FR_ARM : PBM_NORMAL;
               end
            end
            PBM_NORMAL: begin
               if (long_ev) begin
                  st_reg       <= PBM_SEL;
                  sel_cnt      <= 3'h0;
                  ev[`PBM_EV_MENU] <= 1'b1;
               end
            end
            PBM_SEL: begin
               if (long_ev) begin
                  if (kind == PBM_SK_PNET || kind == PBM_SK_EIP) begin
                     o_proto        <= (kind == PBM_SK_EIP) ? `PBM_PROTO_EIP
                                                            : `PBM_PROTO_PNET;
                     o_proto_switch <= 1'b1;
                     o_fb_cfg_reset <= 1'b1;
                     ev[`PBM_EV_PROTO] <= 1'b1;
                     st_reg         <= PBM_PROTO;
                  end else begin
                     res_segs      <= (kind == PBM_SK_SEG1) ? 2'h1 :
                                      (kind == PBM_SK_SEG2) ? 2'h2 : 2'h3;
                     o_store.segs  <= (kind == PBM_SK_SEG1) ? 2'h1 :
                                      (kind == PBM_SK_SEG2) ? 2'h2 : 2'h3;
                     o_store.valid <= 1'b1;
                     st_reg        <= PBM_SAVE_WAIT;
                  end
               end else if (short_ev) begin
                  sel_cnt <= (sel_cnt >= sel_max) ? 3'h0 : sel_cnt + 3'h1;
               end else if (idle_out) begin
                  st_reg <= PBM_NORMAL;
                  ev[`PBM_EV_IDLE] <= 1'b1;
               end
            end
            PBM_SAVE_WAIT: begin
               // Storage side must answer; no timeout here
               if (i_store_done) begin
                  res_ok <= i_store_ok;
                  ev[`PBM_EV_SAVE] <= 1'b1;
                  st_reg <= PBM_SHOW;
               end
            end
            PBM_SHOW: begin
               if (show_end) begin
                  st_reg <= PBM_NORMAL;
               end
            end
            PBM_PROTO: begin
               if (show_end) begin
                  o_restart <= 1'b1;
                  st_reg    <= PBM_STARTUP;
               end
            end
            PBM_FR_ARM: begin
               if (!db_reg) begin
                  fr_rel <= 1'b1;
               end
               if (long_ev && fr_rel) begin
                  o_factory_req <= 1'b1;
                  st_reg        <= PBM_FR_WAIT;
               end else if (idle_out) begin
                  o_restart <= 1'b1;
                  ev[`PBM_EV_IDLE] <= 1'b1;
                  st_reg    <= PBM_STARTUP;
               end
            end
            PBM_FR_WAIT: begin
               if (i_factory_done) begin
                  ev[`PBM_EV_FACT] <= 1'b1;
                  if (i_factory_ok) begin
                     o_proto   <= `PBM_PROTO_PNET;
                     o_restart <= 1'b1;
                     st_reg    <= PBM_STARTUP;
                  end else begin
                     st_reg <= PBM_FR_FAIL;
                  end
               end
            end
            PBM_FR_FAIL: begin
               if (show_end) begin
                  o_restart <= 1'b1;
                  st_reg    <= PBM_STARTUP;
               end
            end
            default: st_reg <= PBM_NORMAL;
         endcase
      end
   end

   function automatic pbm_led_t mk_led(pbm_colour_t c, logic f, logic ph);
      pbm_led_t l;
      l.colour = c;
      l.flash  = f;
      l.lit    = (c != PBM_OFF) && (!f || ph);
      return l;
   endfunction : mk_led

   // Result colour shared by the segment flashes and the memory lamp
   pbm_colour_t res_col;
   assign res_col = res_ok ? PBM_GREEN : PBM_RED;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_seg1_led         <= '0;
         o_seg2_led         <= '0;
         o_mem_led          <= '0;
         o_fault_status_led <= '0;
         o_btn_fn_led       <= '0;
      end else begin
         o_seg1_led         <= mk_led(PBM_OFF, 1'b0, blink);
         o_seg2_led         <= mk_led(PBM_OFF, 1'b0, blink);
         o_mem_led          <= mk_led(PBM_OFF, 1'b0, blink);
         o_fault_status_led <= mk_led(PBM_OFF, 1'b0, blink);
         o_btn_fn_led       <= mk_led(PBM_OFF, 1'b0, blink);
         if (st_reg == PBM_SEL) begin
            if (kind == PBM_SK_SEG1 || kind == PBM_SK_BOTH) begin
               o_seg1_led <= mk_led(PBM_YELLOW, 1'b1, blink);
            end
            if (kind == PBM_SK_SEG2 || kind == PBM_SK_BOTH) begin
               o_seg2_led <= mk_led(PBM_YELLOW, 1'b1, blink);
            end
            if (kind == PBM_SK_PNET || kind == PBM_SK_EIP) begin
               o_fault_status_led <= mk_led(PBM_RED, 1'b1, blink);
            end
         end else if (st_reg == PBM_SHOW) begin
            if (res_segs == 2'h3) begin
               o_mem_led <= mk_led(res_col, 1'b0, blink);
            end else if (res_segs == 2'h1) begin
               o_seg1_led <= mk_led(res_col, 1'b1, blink);
            end else begin
               o_seg2_led <= mk_led(res_col, 1'b1, blink);
            end
         end else if (st_reg == PBM_PROTO) begin
            o_seg1_led <= mk_led(PBM_YELLOW, 1'b1, blink);
            o_seg2_led <= mk_led(PBM_YELLOW, 1'b1, blink);
         end else if (st_reg == PBM_FR_ARM || st_reg == PBM_FR_WAIT) begin
            o_fault_status_led <= mk_led(PBM_YELLOW, 1'b1, blink);
         end else if (st_reg == PBM_FR_FAIL) begin
            o_btn_fn_led <= mk_led(PBM_RED, 1'b1, blink);
         end
      end
   end

   // Set wins over a write-one clear in the same cycle
   assign istat_next = (istat_reg & ~((i_we && i_addr == `PBM_REG_ISTAT) ? i_wdata : 32'h0))
                       | {{(32 - `PBM_EV_W){1'b0}}, ev};

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ctrl_reg  <= `PBM_CTRL_RST;
         imask_reg <= `PBM_IMASK_RST;
         istat_reg <= 32'h0000_0000;
         o_irq     <= 1'b0;
      end else begin
         istat_reg <= istat_next;
         o_irq     <= |(istat_reg & imask_reg);
         if (i_we && i_addr == `PBM_REG_CTRL) begin
            ctrl_reg <= {31'h0, i_wdata[`PBM_CTRL_TWOSEG]};
         end else if (i_we && i_addr == `PBM_REG_IMASK) begin
            imask_reg <= {{(32 - `PBM_EV_W){1'b0}}, i_wdata[`PBM_EV_W-1:0]};
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= 32'h0000_0000;
         if (i_re && i_addr == `PBM_REG_CTRL) begin
            o_rdata <= ctrl_reg;
         end else if (i_re && i_addr == `PBM_REG_STAT) begin
            o_rdata[`PBM_STAT_PROTO] <= o_proto;
            o_rdata[`PBM_STAT_PRESS] <= db_reg;
            o_rdata[`PBM_STAT_SEL]   <= sel_cnt;
            o_rdata[`PBM_STAT_STATE] <= 8'(st_reg);
         end else if (i_re && i_addr == `PBM_REG_ISTAT) begin
            o_rdata <= istat_reg;
         end else if (i_re && i_addr == `PBM_REG_IMASK) begin
            o_rdata <= imask_reg;
         end
      end
   end

   menu_entry_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_NORMAL && long_ev |=> st_reg == PBM_SEL && sel_cnt == 3'h0)
      else $error("hold did not open the menu at segment one");
   seg1_store_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SEL && long_ev && kind == PBM_SK_SEG1
      |=> o_store.valid && o_store.segs == 2'h1 ##1 !o_store.valid)
      else $error("segment one store request wrong");
   seg1_result_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SHOW && $past(st_reg) == PBM_SHOW && res_segs == 2'h1
      |-> o_seg1_led.colour == res_col && o_seg1_led.flash)
      else $error("segment one result colour wrong");
   seg2_step_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SEL && short_ev && !long_ev && sel_cnt == 3'h0 && two_seg
      |=> kind == PBM_SK_SEG2 ##1 o_seg2_led.colour == PBM_YELLOW)
      else $error("short press did not select segment two");
   both_mem_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SHOW && $past(st_reg) == PBM_SHOW && res_segs == 2'h3
      |-> o_mem_led.colour == res_col && !o_mem_led.flash && o_mem_led.lit)
      else $error("memory lamp not steady with result");
   idle_exit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SEL && idle_out && !long_ev && !short_ev |=> st_reg == PBM_NORMAL)
      else $error("menu did not time out");
   proto_init_a: assert property (@(posedge i_mclk)
      $past(i_srst) && !i_srst |-> o_proto == `PBM_PROTO_PNET)
      else $error("protocol not PROFINET after reset");
   proto_go_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_SEL && long_ev && kind == PBM_SK_EIP
      |=> o_proto_switch && o_fb_cfg_reset && o_proto == `PBM_PROTO_EIP)
      else $error("protocol switch not issued");
   fact_req_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      st_reg == PBM_FR_ARM && long_ev && fr_rel |=> o_factory_req && st_reg == PBM_FR_WAIT)
      else $error("factory reset not requested");
   short_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      short_ev |-> !long_ev && $past(hold_cnt) < HOLD_CYC)
      else $error("short press after threshold");

   menu_c: cover property (@(posedge i_mclk) st_reg == PBM_NORMAL ##1 st_reg == PBM_SEL);
   save_c: cover property (@(posedge i_mclk) o_store.valid && o_store.segs == 2'h3);
   fact_c: cover property (@(posedge i_mclk) o_factory_req);

endmodule : pbm_ctrl

// ### sim/pbm_operator.sv
// Operator model: presses the single push button, with contact bounce.
`timescale 1ns/1ps
module pbm_operator (
   input  wire logic i_mclk,
   output logic      o_button
);
   initial o_button = 1'b0;
   // Bounce is shorter than the debounce window, so it must not count as a press
   task automatic press(input int hold, input int gap);
      repeat (2) begin
         @(posedge i_mclk) o_button <= 1'b1;
         @(posedge i_mclk) o_button <= 1'b0;
      end
      @(posedge i_mclk) o_button <= 1'b1;
      repeat (hold) @(posedge i_mclk);
      o_button <= 1'b0;
      repeat (gap) @(posedge i_mclk);
   endtask : press
endmodule : pbm_operator

// ### sim/pbm_ctrl_tb_top.sv
// Testbench for the push-button menu controller.
`timescale 1ns/1ps
module pbm_ctrl_tb_top;
   import pbm_pkg::*;
   localparam int HOLD = 200, IDLE = 300, SHOW = 100, START = 50;
   logic        i_mclk = 0, i_srst, i_we, i_re;
   logic        i_store_done, i_store_ok, i_factory_done, i_factory_ok;
   logic        o_irq, o_proto, o_proto_switch, o_fb_cfg_reset, o_restart, o_factory_req;
   logic        button;
   bit          store_ok, fact_ok;
   logic [3:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   pbm_led_t    s1, s2, mem, flt, bfn;
   pbm_store_t  o_store;
   logic [7:0]  q[$];
   int          fail_count = 0, checked = 0;

   always #5 i_mclk = ~i_mclk;

   pbm_operator op_u (.i_mclk(i_mclk), .o_button(button));
   pbm_ctrl #(.HOLD_CYC(HOLD), .IDLE_CYC(IDLE), .SHOW_CYC(SHOW), .START_CYC(START),
      .DEB_CYC(4), .BLINK_CYC(8)) dut_u (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_button(button), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_seg1_led(s1), .o_seg2_led(s2), .o_mem_led(mem), .o_fault_status_led(flt),
      .o_btn_fn_led(bfn), .o_store(o_store), .i_store_done(i_store_done),
      .i_store_ok(i_store_ok), .o_proto(o_proto), .o_proto_switch(o_proto_switch),
      .o_fb_cfg_reset(o_fb_cfg_reset), .o_restart(o_restart),
      .o_factory_req(o_factory_req), .i_factory_done(i_factory_done),
      .i_factory_ok(i_factory_ok));

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk) {i_we, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_mclk) i_we <= 1'b0;
   endtask : wr

   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] m, exp);
      @(posedge i_mclk) {i_re, i_addr} <= {1'b1, a};
      @(posedge i_mclk) i_re <= 1'b0;
      @(posedge i_mclk) check(nm, o_rdata & m, exp);
   endtask : rd

   task automatic hold;
      op_u.press(HOLD + 20, 10);
   endtask : hold

   task automatic tap(input int k);
      repeat (k) op_u.press(15 + $urandom % 20, 20);
   endtask : tap

   // Every pulse result must match the oldest note; an unexpected one meets 8'hFF
   task automatic take(input logic [7:0] seen);
      check("event", seen, q.size() ? q.pop_front() : 8'hFF);
   endtask : take

   always @(posedge i_mclk) if (!i_srst) begin
      if (o_store.valid) take({6'h08, o_store.segs});
      if (o_proto_switch) take({6'h10, o_fb_cfg_reset, o_proto});
      if (o_restart) take(8'h60);
      if (o_factory_req) take(8'h80);
   end

   // Storage and factory-reset side answer promptly, with the outcome the scenario set
   always @(posedge i_mclk) begin
      {i_store_done, i_store_ok} <= {o_store.valid, store_ok};
      {i_factory_done, i_factory_ok} <= {o_factory_req, fact_ok};
   end

   initial begin
      #400_000;
      fail_count++;
      wrap_up();
   end

   initial begin
      {i_srst, i_we, i_re, i_addr, i_wdata} <= {1'b1, 1'b0, 1'b0, 4'h0, 32'h0};
      void'($urandom(32'h4CEBE12C));
      repeat (8) @(posedge i_mclk);
      i_srst <= 1'b0;
      rd("ctrl", 4'h0, 32'hFFFFFFFF, 32'h1);
      rd("imask", 4'hC, 32'hFFFFFFFF, 32'h0);
      rd("hole", 4'h2, 32'hFFFFFFFF, 32'h0);
      check("proto", o_proto, 1'b0);
      repeat (START) @(posedge i_mclk);
      wr(4'hC, 32'h1F);
      hold();
      check("seg1", {s1.colour, s1.flash}, {PBM_YELLOW, 1'b1});
      rd("istat", 4'h8, 32'h1, 32'h1);
      check("irq", o_irq, 1'b1);
      wr(4'hC, 32'h0);
      repeat (2) @(posedge i_mclk);
      check("irq masked", o_irq, 1'b0);
      wr(4'h8, 32'h1F);
      rd("istat clr", 4'h8, 32'h1, 32'h0);
      store_ok = $urandom % 2;
      q.push_back(8'h21);
      hold();
      check("seg1", {s1.colour, s1.flash}, {store_ok ? PBM_GREEN : PBM_RED, 1'b1});
      repeat (SHOW) @(posedge i_mclk);
      hold();
      tap(1);
      check("seg2", {s2.colour, s2.flash}, {PBM_YELLOW, 1'b1});
      store_ok = 1'b0;
      q.push_back(8'h22);
      hold();
      check("seg2", {s2.colour, s2.flash}, {PBM_RED, 1'b1});
      repeat (SHOW) @(posedge i_mclk);
      hold();
      tap(2);
      check("both", {s1.colour, s1.flash, s2.colour, s2.flash}, 6'h3F);
      store_ok = 1'b1;
      q.push_back(8'h23);
      hold();
      check("mem", {mem.colour, mem.flash, mem.lit}, {PBM_GREEN, 2'b01});
      repeat (SHOW) @(posedge i_mclk);
      hold();
      repeat (IDLE + 20) @(posedge i_mclk);
      rd("state", 4'h4, 32'hFF00, 32'h100);
      rd("idle", 4'h8, 32'h10, 32'h10);
      // Both variants, both protocols: press counts 4,3 then 2,1
      for (int i = 0; i < 4; i++) begin
         if (i == 2) wr(4'h0, 32'h0);
         hold();
         check("fault", flt.flash, 1'b0);
         tap(4 - i);
         check("fault", flt.flash, 1'b1);
         q.push_back(8'h42 | 8'(i % 2 == 0));
         q.push_back(8'h60);
         hold();
         check("proto", {s1.flash, s2.flash}, 2'b11);
         repeat (SHOW + START + 20) @(posedge i_mclk);
      end
      check("proto", o_proto, 1'b0);
      // Failed reset, idle leave, then a successful reset
      for (int i = 0; i < 3; i++) begin
         fact_ok = (i == 2);
         fork
            op_u.press(START + 40, 10);
            begin
               i_srst <= 1'b1;
               repeat (2) @(posedge i_mclk);
               i_srst <= 1'b0;
            end
         join
         check("arm", {flt.colour, flt.flash}, {PBM_YELLOW, 1'b1});
         if (i != 1) begin
            q.push_back(8'h80);
            q.push_back(8'h60);
            hold();
            check("btn fn", {bfn.colour, bfn.flash}, (i == 0) ? {PBM_RED, 1'b1} : 3'h0);
            repeat (SHOW + START + 20) @(posedge i_mclk);
         end else begin
            q.push_back(8'h60);
            repeat (IDLE + START + 40) @(posedge i_mclk);
         end
      end
      check("queue", q.size(), 0);
      wrap_up();
   end
endmodule : pbm_ctrl_tb_top
